// *** verilog/ccog_regs.svh ***
`ifndef CCOG_REGS_SVH
`define CCOG_REGS_SVH
// ****************************************************************
// Register offsets, reset values and field positions.
// ****************************************************************
`define CCOG_NUM_DEC 4
`define CCOG_NUM_MPP 4
`define CCOG_OFS_PAGE 8'h64
`define CCOG_OFS_RST 8'h65
`define CCOG_OFS_MASK 8'h66
`define CCOG_OFS_STAT 8'h67
`define CCOG_OFS_IO 8'h68
`define CCOG_OFS_POL 8'h69
`define CCOG_OFS_P4 8'h70
`define CCOG_OFS_SRC0 8'h71
`define CCOG_OFS_SRC3 8'h74
`define CCOG_OFS_PINSEL 8'h7A
`define CCOG_OFS_GPIO 8'h7C
`define CCOG_OFS_GPIC 8'h7D
`define CCOG_OFS_GPIS 8'h7E
`define CCOG_OFS_LAST 8'h7E
`define CCOG_RST_PAGE 4'h1
`define CCOG_RST_SRC0 8'h10
`define CCOG_RST_SRC1 8'h32
`define CCOG_SRC_MASK 8'h77
`define CCOG_BIT_DPRST 0
`define CCOG_BIT_FULLRST 1
`define CCOG_BIT_P4OPT 0
`define CCOG_BIT_TEST 4
`define CCOG_BIT_FSEL 7
`define CCOG_BIT_MI2C 6
`define CCOG_BIT_ALT 4
`define CCOG_POL_LSB 3
`define CCOG_I2C_FIXED 5'h18
`define CCOG_BIT_LAST 4'h7
`define CCOG_BIT_ACK 4'h8
`define CCOG_P4_MPP_MASK 4'hD
`define CCOG_TRIG_RISE 2'h0
`define CCOG_TRIG_FALL 2'h1
`define CCOG_TRIG_HIGH 2'h2
`define CCOG_TRIG_LOW 2'h3
`endif

// *** verilog/ccog_pkg.sv ***
package ccog_pkg;
	// Host serial engine states.
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_RDATA} ccog_i2c_state_type;
	// One register write request, address and data.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} ccog_wr_type;
endpackage

// *** verilog/ccog_top.sv ***
`timescale 1ns/1ps
`include "ccog_regs.svh"
module ccog_top #(
	parameter int NUM_DEC = `CCOG_NUM_DEC,
	parameter int NUM_MPP = `CCOG_NUM_MPP
) (
	// System clock and reset.
	input wire logic sys_clk,
	input wire logic reset,
	// Host serial bus, open drain data.
	input wire logic scl_clk,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Address straps.
	input wire logic [1:0] strap_address_bits,
	// Decoder register spaces.
	output logic [NUM_DEC-1:0] dec_wr_en,
	output ccog_pkg::ccog_wr_type dec_wr,
	input wire logic [NUM_DEC*8-1:0] dec_rd_data,
	input wire logic [NUM_DEC-1:0] dec_irq,
	// Soft reset pulses.
	output logic full_chip_reset,
	output logic datapath_reset,
	// Output port configuration.
	output logic [3:0] port_pin_direction,
	output logic [1:0] port0_mux_mode,
	output logic [1:0] port1_mux_mode,
	output logic [15:0] port0_source_select,
	output logic [15:0] port1_source_select,
	input wire logic [4:0] pixclk_in,
	output logic [4:0] pixclk_out,
	// Fifth port data and shared pins.
	input wire logic [7:0] video_out_port4,
	input wire logic [3:0] audio_core_out,
	input wire logic [3:0] audio_core_oe,
	output logic [3:0] audio_pin_out,
	output logic [3:0] audio_pin_oe,
	output logic interrupt_out_pin_out,
	output logic interrupt_out_pin_oe,
	// Multipurpose pins.
	input wire logic [NUM_MPP-1:0] mpp_in,
	output logic [NUM_MPP-1:0] mpp_out,
	output logic [NUM_MPP-1:0] mpp_oe
);
	// ****************************************************************
	// Elaboration checks.
	// ****************************************************************
	if (NUM_DEC != `CCOG_NUM_DEC || NUM_MPP != `CCOG_NUM_MPP)
	begin : g_chk
		$error("ccog_top supports four decoders and four pins only.");
	end

	// ****************************************************************
	// Link domain: host serial engine on the bus clock.
	// ****************************************************************
	logic start_tog_r;
	logic start_seen_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] rx_r;
	logic [7:0] tx_r;
	logic [7:0] reg_ptr_r;
	logic ack_r;
	logic sda_oe_r;
	logic wr_tog_r;
	ccog_pkg::ccog_wr_type wr_req_r;
	ccog_pkg::ccog_i2c_state_type state_r;
	logic [1:0] strap_r;
	logic [7:0] rd_data_r;
	logic new_start;
	logic [7:0] rx_byte;
	logic byte_done;

	assign new_start = start_tog_r != start_seen_r;
	assign rx_byte = {rx_r[6:0], sda_in};
	assign byte_done = !new_start && bit_cnt_r == `CCOG_BIT_LAST;

	// A falling data line while the clock is high marks a start.
	always_ff @(negedge sda_in or posedge reset)
	begin
		if (reset)
			start_tog_r <= 1'b0;
		else if (scl_clk)
			start_tog_r <= ~start_tog_r;
	end

	// Bit counter and receive shifter; a start restarts the byte.
	always_ff @(posedge scl_clk or posedge reset)
	begin
		if (reset)
		begin
			start_seen_r <= 1'b0;
			bit_cnt_r <= 4'h0;
			rx_r <= 8'h00;
		end
		else if (new_start)
		begin
			start_seen_r <= start_tog_r;
			bit_cnt_r <= 4'h1;
			rx_r <= {7'h00, sda_in};
		end
		else if (bit_cnt_r == `CCOG_BIT_ACK)
			bit_cnt_r <= 4'h0;
		else
		begin
			bit_cnt_r <= bit_cnt_r + 4'h1;
			rx_r <= rx_byte;
		end
	end

	// Transfer state, acknowledge and register pointer.
	always_ff @(posedge scl_clk or posedge reset)
	begin
		if (reset)
		begin
			state_r <= ccog_pkg::ST_IDLE;
			ack_r <= 1'b0;
			reg_ptr_r <= 8'h00;
		end
		else if (new_start)
		begin
			state_r <= ccog_pkg::ST_ADDR;
			ack_r <= 1'b0;
		end
		else if (bit_cnt_r == `CCOG_BIT_ACK)
		begin
			ack_r <= 1'b0;
			if (state_r == ccog_pkg::ST_RDATA && !ack_r)
			begin
				if (sda_in)
					state_r <= ccog_pkg::ST_IDLE; // Master ends the read with a nack.
				else
					reg_ptr_r <= reg_ptr_r + 8'h01;
			end
		end
		else if (byte_done)
		begin
			unique case (state_r)
				ccog_pkg::ST_IDLE, ccog_pkg::ST_RDATA:
					ack_r <= 1'b0;
				ccog_pkg::ST_ADDR:
				begin
					if (rx_byte[7:1] == {`CCOG_I2C_FIXED, strap_r})
					begin
						ack_r <= 1'b1;
						state_r <= rx_byte[0] ? ccog_pkg::ST_RDATA : ccog_pkg::ST_REG;
					end
					else
						state_r <= ccog_pkg::ST_IDLE;
				end
				ccog_pkg::ST_REG:
				begin
					ack_r <= 1'b1;
					reg_ptr_r <= rx_byte;
					state_r <= ccog_pkg::ST_WDATA;
				end
				ccog_pkg::ST_WDATA:
				begin
					ack_r <= 1'b1;
					reg_ptr_r <= reg_ptr_r + 8'h01;
				end
			endcase
		end
	end

	// Write requests cross to the system clock by a toggle.
	always_ff @(posedge scl_clk or posedge reset)
	begin
		if (reset)
		begin
			wr_tog_r <= 1'b0;
			wr_req_r <= '0;
		end
		else if (byte_done && state_r == ccog_pkg::ST_WDATA)
		begin
			wr_tog_r <= ~wr_tog_r;
			wr_req_r <= '{addr: reg_ptr_r, data: rx_byte};
		end
	end

	// Data line drive on the falling clock: acknowledge or read bits.
	always_ff @(negedge scl_clk or posedge reset)
	begin
		if (reset)
		begin
			sda_oe_r <= 1'b0;
			tx_r <= 8'h00;
		end
		else if (ack_r && bit_cnt_r == `CCOG_BIT_ACK)
			sda_oe_r <= 1'b1;
		else if (state_r == ccog_pkg::ST_RDATA && bit_cnt_r == 4'h0)
		begin
			tx_r <= {rd_data_r[6:0], 1'b0};
			sda_oe_r <= ~rd_data_r[7];
		end
		else if (state_r == ccog_pkg::ST_RDATA && bit_cnt_r < `CCOG_BIT_ACK)
		begin
			tx_r <= {tx_r[6:0], 1'b0};
			sda_oe_r <= ~tx_r[7];
		end
		else
			sda_oe_r <= 1'b0;
	end

	assign sda_out = 1'b0;
	assign sda_oe = sda_oe_r;

	// ****************************************************************
	// System domain: crossings and strap capture.
	// ****************************************************************
	logic [2:0] wt_sync_r;
	logic [7:0] rp_s1_r;
	logic [7:0] rp_s2_r;
	logic [1:0] strap_s1_r;
	logic [1:0] strap_s2_r;
	logic strap_done_r;
	logic [1:0] strap_wait_r;
	logic [NUM_MPP-1:0] mi_s1_r;
	logic [NUM_MPP-1:0] mi_s2_r;
	logic [NUM_MPP-1:0] mi_s3_r;
	logic wr_stb;

	// Toggle, pointer, strap and pin synchronisers.
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			wt_sync_r <= 3'h0;
			rp_s1_r <= 8'h00;
			rp_s2_r <= 8'h00;
			strap_s1_r <= 2'h0;
			strap_s2_r <= 2'h0;
			mi_s1_r <= '0;
			mi_s2_r <= '0;
			mi_s3_r <= '0;
		end
		else
		begin
			wt_sync_r <= {wt_sync_r[1:0], wr_tog_r};
			rp_s1_r <= reg_ptr_r;
			rp_s2_r <= rp_s1_r;
			strap_s1_r <= strap_address_bits;
			strap_s2_r <= strap_s1_r;
			mi_s1_r <= mpp_in;
			mi_s2_r <= mi_s1_r;
			mi_s3_r <= mi_s2_r;
		end
	end

	assign wr_stb = wt_sync_r[2] ^ wt_sync_r[1];

	// Strap levels are caught once the synchroniser holds real pin levels; a pulled-up pin reads 1.
	// The wait stops the reset value of the synchroniser from being taken as the address.
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			strap_r <= 2'h0;
			strap_wait_r <= 2'h0;
			strap_done_r <= 1'b0;
		end
		else
		begin
			strap_wait_r <= {strap_wait_r[0], 1'b1};
			if (strap_wait_r[1] && !strap_done_r)
			begin
				strap_r <= strap_s2_r;
				strap_done_r <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Register file.
	// ****************************************************************
	logic [3:0] page_r;
	logic [3:0] dec_mask_r;
	logic [7:0] io_r;
	logic [4:0] pol_r;
	logic p4opt_r;
	logic test_r;
	logic [7:0] src_r [4];
	logic fsel_r;
	logic mi2c_r;
	logic alt_r;
	logic [7:0] gpio_r;
	logic [3:0] gpi_mask_r;
	logic [1:0] trig_r;
	logic [3:0] event_r;
	logic full_rst_r;
	logic dp_rst_r;
	logic own_addr;
	logic [7:0] wa;
	logic [7:0] wd;

	assign wa = wr_req_r.addr;
	assign wd = wr_req_r.data;
	assign own_addr = wa >= `CCOG_OFS_PAGE && wa <= `CCOG_OFS_LAST;

	// Chip settings; the full soft reset returns them to defaults.
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			page_r <= `CCOG_RST_PAGE;
			dec_mask_r <= 4'h0;
			io_r <= 8'h00;
			pol_r <= 5'h00;
			p4opt_r <= 1'b0;
			test_r <= 1'b0;
			src_r <= '{`CCOG_RST_SRC0, `CCOG_RST_SRC1, `CCOG_RST_SRC0, `CCOG_RST_SRC1};
		end
		else if (full_rst_r)
		begin
			page_r <= `CCOG_RST_PAGE;
			dec_mask_r <= 4'h0;
			io_r <= 8'h00;
			pol_r <= 5'h00;
			p4opt_r <= 1'b0;
			test_r <= 1'b0;
			src_r <= '{`CCOG_RST_SRC0, `CCOG_RST_SRC1, `CCOG_RST_SRC0, `CCOG_RST_SRC1};
		end
		else if (wr_stb)
		begin
			if (wa == `CCOG_OFS_PAGE)
				page_r <= wd[3:0];
			if (wa == `CCOG_OFS_MASK)
				dec_mask_r <= wd[3:0];
			if (wa == `CCOG_OFS_IO)
				io_r <= wd;
			if (wa == `CCOG_OFS_POL)
				pol_r <= wd[7:`CCOG_POL_LSB];
			if (wa == `CCOG_OFS_P4)
			begin
				p4opt_r <= wd[`CCOG_BIT_P4OPT];
				test_r <= wd[`CCOG_BIT_TEST];
			end
			for (int i = 0; i < 4; i++)
			begin
				if (wa == `CCOG_OFS_SRC0 + 8'(i))
					src_r[i] <= wd & `CCOG_SRC_MASK;
			end
		end
	end

	// Pin settings survive the full soft reset.
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			fsel_r <= 1'b0;
			mi2c_r <= 1'b0;
			alt_r <= 1'b0;
			gpio_r <= 8'h00;
			gpi_mask_r <= 4'h0;
			trig_r <= `CCOG_TRIG_RISE;
		end
		else if (wr_stb)
		begin
			if (wa == `CCOG_OFS_PINSEL)
			begin
				fsel_r <= wd[`CCOG_BIT_FSEL];
				mi2c_r <= wd[`CCOG_BIT_MI2C];
				alt_r <= wd[`CCOG_BIT_ALT];
			end
			if (wa == `CCOG_OFS_GPIO)
				gpio_r <= wd;
			if (wa == `CCOG_OFS_GPIC)
			begin
				gpi_mask_r <= wd[3:0];
				trig_r <= wd[5:4];
			end
		end
	end

	// Soft reset pulses and the fanned-out decoder write.
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			full_rst_r <= 1'b0;
			dp_rst_r <= 1'b0;
			dec_wr_en <= '0;
			dec_wr <= '0;
		end
		else
		begin
			full_rst_r <= wr_stb && wa == `CCOG_OFS_RST && wd[`CCOG_BIT_FULLRST];
			dp_rst_r <= wr_stb && wa == `CCOG_OFS_RST && wd[`CCOG_BIT_DPRST];
			dec_wr_en <= (wr_stb && !own_addr) ? page_r : 4'h0;
			if (wr_stb)
				dec_wr <= wr_req_r;
		end
	end

	assign full_chip_reset = full_rst_r;
	assign datapath_reset = dp_rst_r;
	assign port_pin_direction = io_r[3:0];
	assign port0_mux_mode = io_r[5:4];
	assign port1_mux_mode = io_r[7:6];
	assign port0_source_select = {src_r[1], src_r[0]};
	assign port1_source_select = {src_r[3], src_r[2]};
	assign pixclk_out = pixclk_in ^ {pol_r[0], pol_r[4:1]};

	// Read data for the pointer; decoder space comes from the lowest set page bit.
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			rd_data_r <= 8'h00;
		else if (rp_s2_r < `CCOG_OFS_PAGE || rp_s2_r > `CCOG_OFS_LAST)
		begin
			rd_data_r <= 8'h00;
			for (int i = NUM_DEC - 1; i >= 0; i--)
			begin
				if (page_r[i])
					rd_data_r <= dec_rd_data[i*8 +: 8];
			end
		end
		else if (rp_s2_r >= `CCOG_OFS_SRC0 && rp_s2_r <= `CCOG_OFS_SRC3)
			rd_data_r <= src_r[2'(rp_s2_r - `CCOG_OFS_SRC0)];
		else
		begin
			unique case (rp_s2_r)
				`CCOG_OFS_PAGE: rd_data_r <= {4'h0, page_r};
				`CCOG_OFS_MASK: rd_data_r <= {4'h0, dec_mask_r};
				`CCOG_OFS_STAT: rd_data_r <= {4'h0, dec_irq};
				`CCOG_OFS_IO: rd_data_r <= io_r;
				`CCOG_OFS_POL: rd_data_r <= {pol_r, 3'h0};
				`CCOG_OFS_P4: rd_data_r <= {3'h0, test_r, 3'h0, p4opt_r};
				`CCOG_OFS_PINSEL: rd_data_r <= {fsel_r, mi2c_r, 1'b0, alt_r, 4'h0};
				`CCOG_OFS_GPIO: rd_data_r <= gpio_r;
				`CCOG_OFS_GPIC: rd_data_r <= {2'h0, trig_r, gpi_mask_r};
				`CCOG_OFS_GPIS: rd_data_r <= {event_r, mi_s2_r};
				default: rd_data_r <= 8'h00;
			endcase
		end
	end

	// ****************************************************************
	// Multipurpose pins, events and shared pins.
	// ****************************************************************
	logic gpio_en;
	logic [3:0] gpi_act;
	logic [3:0] gpo_en;
	logic [3:0] cond;
	logic [3:0] p4_mpp;
	logic irq_r;
	logic [3:0] ev_clr;

	assign gpio_en = !test_r && !mi2c_r;
	assign gpo_en = {4{gpio_en && !fsel_r}} & gpio_r[7:4];
	assign gpi_act = {4{gpio_en && !alt_r}} & ~gpio_r[7:4];
	assign p4_mpp = {video_out_port4[2], video_out_port4[1], 1'b0, video_out_port4[0]};
	assign ev_clr = (wr_stb && wa == `CCOG_OFS_GPIS) ? wd[7:4] : 4'h0;

	// Event condition per trigger code.
	always_comb
	begin
		unique case (trig_r)
			`CCOG_TRIG_RISE: cond = mi_s2_r & ~mi_s3_r;
			`CCOG_TRIG_FALL: cond = ~mi_s2_r & mi_s3_r;
			`CCOG_TRIG_HIGH: cond = mi_s2_r;
			`CCOG_TRIG_LOW: cond = ~mi_s2_r;
		endcase
	end

	// Sticky event status; a new event wins over a clear.
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			event_r <= 4'h0;
		else
			event_r <= (event_r & ~ev_clr) | (cond & gpi_act);
	end

	// Interrupt from unmasked pin events and enabled decoders.
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			irq_r <= 1'b0;
		else
			irq_r <= |(event_r & ~gpi_mask_r) || |(dec_irq & dec_mask_r);
	end

	// Registered pin drive; the fifth port takes the shared pins over.
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			mpp_out <= '0;
			mpp_oe <= '0;
			audio_pin_out <= 4'h0;
			audio_pin_oe <= 4'h0;
			interrupt_out_pin_out <= 1'b0;
			interrupt_out_pin_oe <= 1'b0;
		end
		else if (p4opt_r)
		begin
			mpp_out <= (p4_mpp & `CCOG_P4_MPP_MASK) | (gpio_r[3:0] & ~`CCOG_P4_MPP_MASK);
			mpp_oe <= `CCOG_P4_MPP_MASK | gpo_en;
			audio_pin_out <= {video_out_port4[7:5], video_out_port4[3]};
			audio_pin_oe <= 4'hF;
			interrupt_out_pin_out <= video_out_port4[4];
			interrupt_out_pin_oe <= 1'b1;
		end
		else
		begin
			mpp_out <= gpio_r[3:0];
			mpp_oe <= gpo_en;
			audio_pin_out <= audio_core_out;
			audio_pin_oe <= audio_core_oe;
			interrupt_out_pin_out <= irq_r;
			interrupt_out_pin_oe <= 1'b1;
		end
	end

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence s_rise0;
		trig_r == `CCOG_TRIG_RISE && gpi_act[0] && mi_s2_r[0] && !mi_s3_r[0];
	endsequence
	sequence s_io_write;
		wr_stb && wa == `CCOG_OFS_IO && !full_rst_r;
	endsequence

	property p_strap;
		$rose(strap_done_r) |-> strap_r == $past(strap_s2_r);
	endproperty
	a_strap: assert property (p_strap) else $error("Strap not caught.");

	property p_full_reset;
		full_rst_r |=> page_r == `CCOG_RST_PAGE && dec_mask_r == 4'h0 && !p4opt_r;
	endproperty
	a_full_reset: assert property (p_full_reset) else $error("Full reset missed.");

	property p_fanout;
		wr_stb && !own_addr |=> dec_wr_en == $past(page_r) && dec_wr.data == $past(wd);
	endproperty
	a_fanout: assert property (p_fanout) else $error("Decoder write not fanned out.");

	property p_gpo;
		gpio_en && !fsel_r && gpio_r[5] && !p4opt_r |=> mpp_oe[1] && mpp_out[1] == $past(gpio_r[1]);
	endproperty
	a_gpo: assert property (p_gpo) else $error("Output pin not driven.");

	property p_port4;
		p4opt_r |=> audio_pin_oe == 4'hF && interrupt_out_pin_out == $past(video_out_port4[4]);
	endproperty
	a_port4: assert property (p_port4) else $error("Port four pins wrong.");

	property p_event;
		s_rise0 |=> event_r[0] ##1 irq_r || gpi_mask_r[0];
	endproperty
	a_event: assert property (p_event) else $error("Rising event lost.");

	property p_gpio_off;
		!gpio_en && !p4opt_r |=> mpp_oe == 4'h0;
	endproperty
	a_gpio_off: assert property (p_gpio_off) else $error("Pin driven while disabled.");

	property p_io_mode;
		s_io_write |=> port_pin_direction == $past(wd[3:0]) && port1_mux_mode == $past(wd[7:6]);
	endproperty
	a_io_mode: assert property (p_io_mode) else $error("Port mode not taken.");

	property p_addr_ack;
		@(posedge scl_clk) disable iff (reset)
		byte_done && state_r == ccog_pkg::ST_ADDR && rx_byte[7:1] == {`CCOG_I2C_FIXED, strap_r}
		|=> ack_r && state_r != ccog_pkg::ST_ADDR;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("Own address not acked.");
endmodule // ccog_top

// *** testbench/ccog_host_model.sv ***
`timescale 1ns/1ps
// ****************************************
// Host bus master model.
// ****************************************
module ccog_host_model (
	// Bus wires.
	output logic scl_clk,
	output logic sda_line,
	input wire logic sda_oe
);
	logic pull_low;
	// The line has a pull-up, so it is low only while some party pulls it.
	assign sda_line = ~(pull_low | sda_oe);
	// The bus clock stands high between frames.
	initial
	begin
		scl_clk = 1'b1;
		pull_low = 1'b0;
	end
	// Data changes in the low phase and is sampled in the high phase.
	// Each step is a quarter of the 30 ns bus clock period.
	task automatic bit_io(input logic b, output logic r);
		#7.5 pull_low = ~b;
		#7.5 scl_clk = 1'b1;
		#7.5 r = sda_line;
		#7.5 scl_clk = 1'b0;
	endtask
	// A start or repeated start leaves the clock low.
	task automatic start();
		#7.5 pull_low = 1'b0;
		#7.5 scl_clk = 1'b1;
		#7.5 pull_low = 1'b1;
		#7.5 scl_clk = 1'b0;
	endtask
	// A stop leaves the bus idle.
	task automatic stop();
		#7.5 pull_low = 1'b1;
		#7.5 scl_clk = 1'b1;
		#7.5 pull_low = 1'b0;
	endtask
	// One byte, most significant bit first, then the acknowledge bit.
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(tx[i], r);
			rx[i] = r;
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	// Register write: device address, register pointer, one data byte.
	task automatic wr(input logic [7:0] dev, input logic [7:0] ra, input logic [7:0] d,
		output logic ack);
		logic [7:0] rx;
		logic a1, a2, a3;
		start();
		xfer(dev, rx, a1);
		xfer(ra, rx, a2);
		xfer(d, rx, a3);
		stop();
		ack = a1 & a2 & a3;
	endtask
	// Register read: pointer write, repeated start, one byte ended by a nack.
	task automatic rd(input logic [7:0] dev, input logic [7:0] ra, output logic [7:0] d,
		output logic ack);
		logic [7:0] rx;
		logic a1, a2, a3, n;
		start();
		xfer(dev, rx, a1);
		xfer(ra, rx, a2);
		start();
		xfer(dev | 8'h01, rx, a3);
		xfer(8'hFF, d, n);
		stop();
		ack = a1 & a2 & a3;
	endtask
endmodule // ccog_host_model

// *** testbench/test_chip_control_output_gpio.sv ***
`timescale 1ns/1ps
// ****************************************
// Testbench.
// ****************************************
module test_chip_control_output_gpio;
	typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] q;} ccog_row_type;
	logic sys_clk, reset, scl_clk, sda_in, sda_out, sda_oe, irq_out, irq_oe;
	logic full_chip_reset, datapath_reset, ack;
	logic [1:0] strap_address_bits, port0_mux_mode, port1_mux_mode;
	logic [3:0] dec_wr_en, dec_irq, port_pin_direction, audio_core_out, audio_core_oe;
	logic [3:0] audio_pin_out, audio_pin_oe, mpp_in, mpp_out, mpp_oe, en_seen;
	logic [4:0] pixclk_in, pixclk_out;
	logic [7:0] video_out_port4, rv, dev;
	logic [15:0] port0_source_select, port1_source_select, wr_seen, gate[3];
	logic [31:0] dec_rd_data;
	ccog_pkg::ccog_wr_type dec_wr;
	ccog_row_type rows[14];
	int err_total = 0;
	int total_checks = 0;
	int cyc = 0;
	int dp_cnt = 0;
	int fr_cnt = 0;
	ccog_top ccog_top_inst (.sys_clk(sys_clk), .reset(reset), .scl_clk(scl_clk),
		.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
		.strap_address_bits(strap_address_bits), .dec_wr_en(dec_wr_en), .dec_wr(dec_wr),
		.dec_rd_data(dec_rd_data), .dec_irq(dec_irq), .full_chip_reset(full_chip_reset),
		.datapath_reset(datapath_reset), .port_pin_direction(port_pin_direction),
		.port0_mux_mode(port0_mux_mode), .port1_mux_mode(port1_mux_mode),
		.port0_source_select(port0_source_select), .port1_source_select(port1_source_select),
		.pixclk_in(pixclk_in), .pixclk_out(pixclk_out), .video_out_port4(video_out_port4),
		.audio_core_out(audio_core_out), .audio_core_oe(audio_core_oe),
		.audio_pin_out(audio_pin_out), .audio_pin_oe(audio_pin_oe),
		.interrupt_out_pin_out(irq_out), .interrupt_out_pin_oe(irq_oe),
		.mpp_in(mpp_in), .mpp_out(mpp_out), .mpp_oe(mpp_oe));
	ccog_host_model ccog_host_model_inst (.scl_clk(scl_clk), .sda_line(sda_in), .sda_oe(sda_oe));
	// System clock, 4 ns period.
	always #2 sys_clk = ~sys_clk;
	// Catch decoder write strobes and reset pulses, and cut a hung run short.
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (|dec_wr_en)
		begin
			en_seen <= dec_wr_en;
			wr_seen <= dec_wr;
		end
		dp_cnt <= dp_cnt + int'(datapath_reset);
		fr_cnt <= fr_cnt + int'(full_chip_reset);
		if (cyc == 90000)
		begin
			err_total++;
			report_and_stop();
		end
	end
	// Compare and count.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Register access through the host bus model.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		ccog_host_model_inst.wr(dev, a, d, ack);
		chk(ack, 1'b1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] q);
		ccog_host_model_inst.rd(dev, a, rv, ack);
		chk({ack, rv}, {1'b1, q});
	endtask
	// Reset with a given strap setting.
	task automatic do_reset(input logic [1:0] s);
		@(posedge sys_clk);
		reset <= 1'b1;
		strap_address_bits <= s;
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (8) @(posedge sys_clk);
	endtask
	// Print the counts and the verdict, then end the run.
	task report_and_stop();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Main sequence.
	initial
	begin
		sys_clk = 1'b0;
		reset = 1'b1;
		strap_address_bits = 2'h2;
		dec_rd_data = 32'h44332211;
		dec_irq = 4'h6;
		pixclk_in = 5'h00;
		video_out_port4 = 8'h5A;
		audio_core_out = 4'h3;
		audio_core_oe = 4'hF;
		mpp_in = 4'h0;
		dev = 8'hC4;
		rows = '{'{1'b0, 8'h64, 8'h00, 8'h01}, '{1'b0, 8'h66, 8'h00, 8'h00},
			'{1'b0, 8'h68, 8'h00, 8'h00}, '{1'b0, 8'h69, 8'h00, 8'h00},
			'{1'b0, 8'h71, 8'h00, 8'h10}, '{1'b0, 8'h72, 8'h00, 8'h32},
			'{1'b1, 8'h64, 8'h05, 8'h05}, '{1'b1, 8'h66, 8'h0A, 8'h0A},
			'{1'b1, 8'h68, 8'h9B, 8'h9B}, '{1'b1, 8'h69, 8'hA8, 8'hA8},
			'{1'b1, 8'h71, 8'hFF, 8'h77}, '{1'b1, 8'h67, 8'h0F, 8'h06},
			'{1'b1, 8'h65, 8'h00, 8'h00}, '{1'b1, 8'h6A, 8'h55, 8'h00}};
		gate = '{16'h7010, 16'h7A40, 16'h7A80};
		do_reset(2'h2);
		foreach (rows[i])
		begin
			if (rows[i].w)
				wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].q);
		end
		chk({port1_mux_mode, port0_mux_mode, port_pin_direction}, 8'h9B);
		chk(port0_source_select, 16'h3277);
		chk(port1_source_select, 16'h3210);
		chk(irq_out, 1'b1);
		chk(pixclk_out, 5'h1A);
		@(posedge sys_clk);
		pixclk_in <= 5'h1F;
		@(posedge sys_clk);
		chk(pixclk_out, 5'h05);
		// Decoder space writes go to every selected page; reads use one page.
		wr(8'h10, 8'h5A);
		chk({en_seen, wr_seen}, {4'h5, 8'h10, 8'h5A});
		wr(8'h64, 8'h02);
		rd(8'h10, 8'h22);
		// Soft resets.
		wr(8'h7C, 8'hF5);
		wr(8'h65, 8'h01);
		chk({dp_cnt[15:0], fr_cnt[15:0]}, 32'h00010000);
		rd(8'h66, 8'h0A);
		wr(8'h65, 8'h02);
		chk(fr_cnt, 1);
		rd(8'h64, 8'h01);
		rd(8'h66, 8'h00);
		rd(8'h7C, 8'hF5);
		chk({mpp_oe, mpp_out}, 8'hF5);
		// Each gating bit alone releases the pins.
		foreach (gate[i])
		begin
			wr(gate[i][15:8], gate[i][7:0]);
			chk(mpp_oe, 4'h0);
			wr(gate[i][15:8], 8'h00);
		end
		wr(8'h7C, 8'h00);
		chk(mpp_oe, 4'h0);
		// Every trigger code: held low after a clear, then a rising edge.
		for (int c = 0; c < 4; c++)
		begin
			@(posedge sys_clk);
			mpp_in <= 4'h0;
			wr(8'h7D, {2'h0, c[1:0], 4'h0});
			wr(8'h7E, 8'hF0);
			rd(8'h7E, {{4{c == 3}}, 4'h0});
			chk(irq_out, (4'h8 >> c) & 4'h1);
			@(posedge sys_clk);
			mpp_in <= 4'hF;
			repeat (8) @(posedge sys_clk);
			chk(irq_out, (4'hD >> c) & 4'h1);
			rd(8'h7E, {{4{c != 1}}, 4'hF});
		end
		// Alternate select keeps the pins from acting as inputs.
		wr(8'h7A, 8'h10);
		wr(8'h7D, 8'h20);
		wr(8'h7E, 8'hF0);
		rd(8'h7E, 8'h0F);
		wr(8'h7A, 8'h00);
		wr(8'h7D, 8'h0F);
		chk(irq_out, 1'b0);
		// Fifth port onto the shared pins.
		chk(audio_pin_out, 4'h3);
		wr(8'h70, 8'h01);
		chk({audio_pin_out, irq_out, mpp_out & 4'hD, mpp_oe & 4'hD}, 13'h0B4D);
		chk({irq_oe, audio_pin_oe, sda_out}, 6'h3E);
		// Wrong address is ignored; a new strap gives a new address.
		ccog_host_model_inst.wr(8'hC0, 8'h66, 8'h0F, ack);
		chk(ack, 1'b0);
		rd(8'h66, 8'h00);
		do_reset(2'h1);
		dev = 8'hC2;
		rd(8'h64, 8'h01);
		report_and_stop();
	end
endmodule // test_chip_control_output_gpio
